// >>> hw/reload_timer_pkg.sv
// package: register map, field layout and reset values of the 16-bit reload timer
package reload_timer_pkg;
	localparam int unsigned ADDR_W          = 16;
	localparam int unsigned DATA_W          = 16;
	localparam logic [15:0] OFS_CLK_SEL     = 16'h4200;
	localparam logic [15:0] OFS_RELOAD      = 16'h4202;
	localparam logic [15:0] OFS_COUNTER     = 16'h4204;
	localparam logic [15:0] OFS_CONTROL     = 16'h4206;
	localparam logic [15:0] OFS_IRQ_CTRL    = 16'h4208;
	localparam int unsigned DIV_CODE_LSB    = 0;
	localparam int unsigned DIV_CODE_W      = 4;
	localparam logic [3:0]  DIV_CODE_MAX    = 4'hE;
	localparam int unsigned PRESCALE_W      = 14;
	localparam int unsigned RUN_BIT         = 0;
	localparam int unsigned RESET_CMD_BIT   = 1;
	localparam int unsigned ONESHOT_BIT     = 4;
	localparam int unsigned IRQ_FLAG_BIT    = 0;
	localparam int unsigned IRQ_ENABLE_BIT  = 8;
	localparam logic [15:0] RST_CLK_SEL     = 16'h0000;
	localparam logic [15:0] RST_RELOAD      = 16'h0000;
	localparam logic [15:0] RST_COUNTER     = 16'hFFFF;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} reg_req_t;
endpackage : reload_timer_pkg

// >>> hw/reload_timer.sv
// 16-bit reload timer channel with prescaler, one-shot/repeat and register port
// Notes on behaviour
// - divide code picks clock/1..16384, 0xF reserved
// - reload register read/write, resets to zero
// - counter read-only, resets to all ones
// - mode bit set is one-shot, clear repeat
// - writing one to reset bit resets timer
// - run bit starts and stops counting
// - enable bit gates interrupt request output
// - flag sets on cause, write one clears
`timescale 1ns/1ps
`default_nettype none
module reload_timer
	import reload_timer_pkg::*;
(
	input  wire logic                                  clk_i,
	input  wire logic                                  rst_n_i,
	input  wire reload_timer_pkg::reg_req_t            req_i,
	output var  logic [reload_timer_pkg::DATA_W-1:0]   rdata_o,
	output var  logic                                  irq_o
);
	import reload_timer_pkg::*;

	logic [DIV_CODE_W-1:0] clock_divide_code;
	logic [DATA_W-1:0]     reload_value;
	logic [DATA_W-1:0]     counter_value;
	logic                  oneshot_select;
	logic                  run_control;
	logic                  irq_enable;
	logic                  irq_flag;
	logic [PRESCALE_W-1:0] prescale;
	logic                  tick;
	logic                  underflow;
	logic                  wr_clk_sel;
	logic                  wr_reload;
	logic                  wr_control;
	logic                  wr_irq;
	logic                  timer_reset_cmd;
	logic [DATA_W-1:0]     next_rdata;

	assign wr_clk_sel      = req_i.wr && (req_i.addr == OFS_CLK_SEL);
	assign wr_reload       = req_i.wr && (req_i.addr == OFS_RELOAD);
	assign wr_control      = req_i.wr && (req_i.addr == OFS_CONTROL);
	assign wr_irq          = req_i.wr && (req_i.addr == OFS_IRQ_CTRL);
	assign timer_reset_cmd = wr_control && req_i.wdata[RESET_CMD_BIT];

	// tick fires when the low 'code' bits of the free prescaler are all ones;
	// reserved code 0xF behaves as the slowest ratio rather than stalling
	always_comb begin
		logic [PRESCALE_W-1:0] mask;
		logic [3:0]            code;
		mask = '0;
		code = (clock_divide_code > DIV_CODE_MAX) ? DIV_CODE_MAX : clock_divide_code;
		for (int i = 0; i < PRESCALE_W; i++) begin
			mask[i] = (i < int'(code));
		end
		tick = ((prescale & mask) == mask);
	end

	assign underflow = run_control && tick && (counter_value == '0);

	// prescaler restarts on stop or timer reset so the first period is whole
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prescale <= '0;
		end else if (!run_control || timer_reset_cmd) begin
			prescale <= '0;
		end else begin
			prescale <= prescale + 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clock_divide_code <= RST_CLK_SEL[DIV_CODE_W-1:0];
		end else if (wr_clk_sel) begin
			clock_divide_code <= req_i.wdata[DIV_CODE_LSB +: DIV_CODE_W];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reload_value <= RST_RELOAD;
		end else if (wr_reload) begin
			reload_value <= req_i.wdata;
		end
	end

	// counter has no write path from software
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			counter_value <= RST_COUNTER;
		end else if (timer_reset_cmd) begin
			counter_value <= reload_value;
		end else if (underflow) begin
			counter_value <= reload_value;
		end else if (run_control && tick) begin
			counter_value <= counter_value - 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			oneshot_select <= 1'b0;
		end else if (wr_control) begin
			oneshot_select <= req_i.wdata[ONESHOT_BIT];
		end
	end

	// a software write takes precedence over the one-shot auto stop
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_control <= 1'b0;
		end else if (wr_control) begin
			run_control <= req_i.wdata[RUN_BIT];
		end else if (underflow && oneshot_select) begin
			run_control <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_enable <= 1'b0;
		end else if (wr_irq) begin
			irq_enable <= req_i.wdata[IRQ_ENABLE_BIT];
		end
	end

	// set wins over a same-cycle clear so no underflow is lost
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_flag <= 1'b0;
		end else if (underflow) begin
			irq_flag <= 1'b1;
		end else if (wr_irq && req_i.wdata[IRQ_FLAG_BIT]) begin
			irq_flag <= 1'b0;
		end
	end

	// irq follows next-state values so the output is a flop yet tracks the flag
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= (underflow || (irq_flag && !(wr_irq && req_i.wdata[IRQ_FLAG_BIT])))
				&& (wr_irq ? req_i.wdata[IRQ_ENABLE_BIT] : irq_enable);
		end
	end

	always_comb begin
		next_rdata = '0;
		unique case (req_i.addr)
			OFS_CLK_SEL:  next_rdata[DIV_CODE_LSB +: DIV_CODE_W] = clock_divide_code;
			OFS_RELOAD:   next_rdata = reload_value;
			OFS_COUNTER:  next_rdata = counter_value;
			OFS_CONTROL: begin
				next_rdata[ONESHOT_BIT] = oneshot_select;
				next_rdata[RUN_BIT]     = run_control;
			end
			OFS_IRQ_CTRL: begin
				next_rdata[IRQ_ENABLE_BIT] = irq_enable;
				next_rdata[IRQ_FLAG_BIT]   = irq_flag;
			end
			default:      next_rdata = '0;
		endcase
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= '0;
		end else if (req_i.rd) begin
			rdata_o <= next_rdata;
		end else begin
			rdata_o <= '0;
		end
	end
endmodule : reload_timer
`default_nettype wire

// >>> sim/reload_timer_props.sv
// checker: register port and interrupt output properties
`timescale 1ns/1ps
`default_nettype none
module reload_timer_props
	import reload_timer_pkg::*;
(
	input wire logic                       clk_i,
	input wire logic                       rst_n_i,
	input wire reload_timer_pkg::reg_req_t req_i,
	input wire logic [15:0]                rdata_o,
	input wire logic                       irq_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	sequence rd_at(logic [15:0] a);
		req_i.rd && req_i.addr == a;
	endsequence
	sequence wr_rd(logic [15:0] a);
		req_i.wr && req_i.addr == a ##1 rd_at(a);
	endsequence
	idle_zero_a: assert property (!req_i.rd |=> rdata_o == 16'h0000)
		else $error("read data not zero");
	reload_echo_a: assert property (wr_rd(OFS_RELOAD) |=> rdata_o == $past(req_i.wdata, 2))
		else $error("reload readback");
	clk_echo_a: assert property (wr_rd(OFS_CLK_SEL) |=> rdata_o == ($past(req_i.wdata, 2) & 16'h000F))
		else $error("divide code readback");
	clk_rsvd_a: assert property (rd_at(OFS_CLK_SEL) |=> (rdata_o & 16'hFFF0) == 16'h0000)
		else $error("divide reserved bits");
	ctl_rsvd_a: assert property (rd_at(OFS_CONTROL) |=> (rdata_o & 16'hFFEE) == 16'h0000)
		else $error("control reserved bits");
	irq_rsvd_a: assert property (rd_at(OFS_IRQ_CTRL) |=> (rdata_o & 16'hFEFE) == 16'h0000)
		else $error("irq reserved bits");
	irq_off_a: assert property (req_i.wr && req_i.addr == OFS_IRQ_CTRL && !req_i.wdata[IRQ_ENABLE_BIT] |=> !irq_o)
		else $error("irq not masked");
	unmapped_a: assert property (req_i.rd && !(req_i.addr inside {[16'h4200:16'h4208]}) |=> rdata_o == 16'h0000)
		else $error("unmapped read");
endmodule : reload_timer_props
bind reload_timer reload_timer_props chk_u (.clk_i, .rst_n_i, .req_i, .rdata_o, .irq_o);
`default_nettype wire

// >>> sim/tb.sv
// testbench: register sweep, one-shot underflow, mask and reset
`timescale 1ns/1ps
`default_nettype none
module tb;
	import reload_timer_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	reg_req_t    req = '0;
	logic [15:0] rdata_o;
	logic        irq_o;
	int          err_total = 0;
	int          n_checks = 0;
	logic [15:0] rows [6][3] = '{'{OFS_COUNTER, 16'h1234, 16'hFFFF}, '{OFS_CLK_SEL, 16'hFFF5, 16'h0005},
		'{OFS_RELOAD, 16'hA5C3, 16'hA5C3}, '{OFS_CONTROL, 16'h0010, 16'h0010},
		'{OFS_IRQ_CTRL, 16'hFFFE, 16'h0100}, '{16'h4300, 16'hFFFF, 16'h0000}};
	always #4 clk_i = ~clk_i;
	reload_timer dut_u (.clk_i, .rst_n_i, .req_i(req), .rdata_o, .irq_o);
	task automatic chk(input logic [15:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// strobe stays up until the next request or an explicit release
	task automatic wr(input logic [15:0] a, d);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_i);
	endtask : wr
	task automatic rd(input logic [15:0] a, e);
		req <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge clk_i);
		req <= '0;
		@(negedge clk_i);
		chk(rdata_o, e);
		@(posedge clk_i);
	endtask : rd
	task automatic summarize;
		$display("checks=%0d errors=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize
	initial begin
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		for (int i = 0; i < 6; i++) begin
			wr(rows[i][0], rows[i][1]);
			rd(rows[i][0], rows[i][2]);
		end
		wr(OFS_RELOAD, 16'h0002);
		wr(OFS_CLK_SEL, 16'h0000);
		wr(OFS_CONTROL, 16'h0012);
		rd(OFS_COUNTER, 16'h0002);
		wr(OFS_CONTROL, 16'h0011);
		req <= '0;
		// poll on the falling edge so the registered irq has settled
		for (int i = 0; i < 20 && irq_o !== 1'b1; i++)
			@(negedge clk_i);
		if (irq_o !== 1'b1) begin
			err_total++;
			summarize();
		end
		@(posedge clk_i);
		rd(OFS_CONTROL, 16'h0010);
		rd(OFS_COUNTER, 16'h0002);
		wr(OFS_IRQ_CTRL, 16'h0100);
		rd(OFS_IRQ_CTRL, 16'h0101);
		wr(OFS_IRQ_CTRL, 16'h0101);
		rd(OFS_IRQ_CTRL, 16'h0100);
		wr(OFS_IRQ_CTRL, 16'h0000);
		wr(OFS_CONTROL, 16'h0013);
		req <= '0;
		repeat (8) @(posedge clk_i);
		chk({15'h0000, irq_o}, 16'h0000);
		rd(OFS_IRQ_CTRL, 16'h0001);
		// repeat mode at /4 with reload 1: underflow every 8 cycles after the start write
		wr(OFS_IRQ_CTRL, 16'h0101);
		wr(OFS_RELOAD, 16'h0001);
		wr(OFS_CLK_SEL, 16'h0002);
		wr(OFS_CONTROL, 16'h0003);
		req <= '0;
		repeat (7) @(posedge clk_i);
		chk({15'h0000, irq_o}, 16'h0000);
		repeat (2) @(posedge clk_i);
		chk({15'h0000, irq_o}, 16'h0001);
		rd(OFS_COUNTER, 16'h0001);
		rd(OFS_CONTROL, 16'h0001);
		wr(OFS_IRQ_CTRL, 16'h0101);
		req <= '0;
		@(posedge clk_i);
		chk({15'h0000, irq_o}, 16'h0000);
		repeat (2) @(posedge clk_i);
		chk({15'h0000, irq_o}, 16'h0001);
		wr(OFS_CONTROL, 16'h0000);
		req <= '0;
		repeat (8) @(posedge clk_i);
		rd(OFS_COUNTER, 16'h0001);
		// reserved code runs at the slowest ratio: first tick 16384 cycles after start
		wr(OFS_IRQ_CTRL, 16'h0101);
		wr(OFS_RELOAD, 16'h0000);
		wr(OFS_CLK_SEL, 16'h000F);
		wr(OFS_CONTROL, 16'h0003);
		req <= '0;
		repeat (16383) @(posedge clk_i);
		chk({15'h0000, irq_o}, 16'h0000);
		repeat (2) @(posedge clk_i);
		chk({15'h0000, irq_o}, 16'h0001);
		rst_n_i <= 1'b0;
		@(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		for (int i = 0; i < 5; i++)
			rd(rows[i][0], i == 0 ? 16'hFFFF : 16'h0000);
		summarize();
	end
endmodule : tb
`default_nettype wire
